// *** verilog/rsc_reset_ctrl.v ***
// reset source control: trip level, cause flags, sequencing
`timescale 1ns/1ps
module rsc_reset_ctrl (
  // clock and power-on reset
  input  wire        clk_sys,
  input  wire        sys_rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // pins and analogue
  input  wire        external_reset_pin_n,
  input  wire        low_supply_trip,
  input  wire        slow_internal_rc,
  // core events, same clock
  input  wire        watchdog_timeout,
  input  wire [4:0]  watchdog_enable_code,
  input  wire        low_power_mode,
  input  wire        halt_enter,
  input  wire        watchdog_clear,
  // outputs to core and analogue
  output reg  [7:0]  trip_level_code,
  output reg         device_reset,
  output reg         pc_sp_clear,
  output reg         watchdog_restart,
  output reg         watchdog_timeout_flag,
  output reg         powerdown_flag,
  output reg         idle_sysclk_keep
);
`include "rsc_defines.vh"

  localparam ST_RUN   = 2'd0;
  localparam ST_HOLD  = 2'd1;
  localparam ST_START = 2'd2;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [1:0] pin_sync;
  reg [1:0] trip_sync;
  reg [1:0] rc_sync;
  reg       rc_last;

  // pins reach logic only through the second stage
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_sync  <= 2'b11;
      trip_sync <= 2'b00;
      rc_sync   <= 2'b00;
      rc_last   <= 1'b0;
    end else begin
      pin_sync  <= {pin_sync[0], external_reset_pin_n};
      trip_sync <= {trip_sync[0], low_supply_trip};
      rc_sync   <= {rc_sync[0], slow_internal_rc};
      rc_last   <= rc_sync[1];
    end
  end

  wire pin_low   = ~pin_sync[1];
  wire supply_lo = trip_sync[1];
  wire slow_rise = rc_sync[1] & ~rc_last;

  // ****************************************
  // code checks and debounce
  // ****************************************
  wire       trip_legal;
  wire       wde_legal;
  wire [1:0] bad_code;
  wire [1:0] bad_fire;

  assign trip_legal = (trip_level_code == `RSC_TRIP_LVL0) |
                      (trip_level_code == `RSC_TRIP_LVL1) |
                      (trip_level_code == `RSC_TRIP_LVL2) |
                      (trip_level_code == `RSC_TRIP_LVL3);
  assign wde_legal  = (watchdog_enable_code == `RSC_WDE_OFF) |
                      (watchdog_enable_code == `RSC_WDE_ON);
  assign bad_code   = {~wde_legal, ~trip_legal};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_deb
      rsc_debounce u_deb (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .slow_rise (slow_rise),
        .fault     (bad_code[gi]),
        .fire      (bad_fire[gi])
      );
    end
  endgenerate

  wire trip_fire = bad_fire[0];
  wire wde_fire  = bad_fire[1];
  wire tmo_norm  = watchdog_timeout & ~low_power_mode;
  wire tmo_low   = watchdog_timeout & low_power_mode;

  // ****************************************
  // wishbone decode
  // ****************************************
  reg  ack;
  wire req   = wb_cyc_i & wb_stb_i & ~ack;
  // every register is one byte wide, so only the lowest lane enables a write
  wire wr    = req & wb_we_i & wb_sel_i[0];
  wire wr_tr = wr & (wb_adr_i == `RSC_OFF_TRIP);
  wire wr_ca = wr & (wb_adr_i == `RSC_OFF_CAUSE);
  wire wr_cs = wr & (wb_adr_i == `RSC_OFF_CLKSRC);

  assign wb_ack_o = ack;

  // ****************************************
  // reset sequencer
  // ****************************************
  reg  [1:0]  state;
  reg  [10:0] sst_cnt;
  reg  [2:0]  clk_src;
  reg  [10:0] sst_load;
  reg  [1:0]  next_state;

  always @* begin
    case (clk_src)
      `RSC_SRC_EXTRC:  sst_load = `RSC_SST_RC;
      `RSC_SRC_FASTRC: sst_load = `RSC_SST_RC;
      `RSC_SRC_FASTXT: sst_load = `RSC_SST_XTAL;
      `RSC_SRC_SLOWXT: sst_load = `RSC_SST_XTAL;
      `RSC_SRC_SLOWRC: sst_load = `RSC_SST_SLOW;
      default:         sst_load = `RSC_SST_RC;
    endcase
  end

  // any full reset source, held ones keep the hold state
  wire full_evt = trip_fire | wde_fire | tmo_norm | pin_low | supply_lo;
  wire held     = pin_low | supply_lo;

  // a low-power timeout runs the startup wait with the core left running;
  // a held source during that wait turns it into a full reset
  reg  lp_wake;
  wire lp_entry     = (state == ST_RUN) & ~full_evt & tmo_low;
  wire next_lp_wake = lp_entry | (lp_wake & (next_state == ST_START));

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (full_evt) begin
          next_state = ST_HOLD;
        end else if (tmo_low) begin
          next_state = ST_START;
        end
      end
      ST_HOLD: begin
        if (!held) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (held) begin
          next_state = ST_HOLD;
        end else if (sst_cnt == 11'd1) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  // power-on enters the startup wait directly
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state            <= ST_START;
      sst_cnt          <= `RSC_SST_RC;
      device_reset     <= 1'b1;
      lp_wake          <= 1'b0;
      pc_sp_clear      <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      state            <= next_state;
      pc_sp_clear      <= 1'b0;
      watchdog_restart <= 1'b0;
      if (next_state == ST_START && state != ST_START) begin
        sst_cnt <= sst_load;
      end else if (state == ST_START && sst_cnt != 11'd0) begin
        sst_cnt <= sst_cnt - 11'd1;
      end
      // low-power timeout only clears pc and sp
      // the reset level follows the next state, so a low-power wake
      // never pulses the core reset while its startup wait runs
      pc_sp_clear  <= lp_entry;
      lp_wake      <= next_lp_wake;
      device_reset <= (next_state != ST_RUN) & ~next_lp_wake;
      // watchdog restarts when core is released
      if (state == ST_START && next_state == ST_RUN) begin
        watchdog_restart <= 1'b1;
      end
    end
  end

  // ****************************************
  // trip level and cause registers
  // ****************************************
  reg bad_wde_flag;
  reg bad_trip_flag;
  reg low_supply_reset_flag;

  // soft resets restore the trip level and keep bit; supply trip does not
  wire soft_full = trip_fire | wde_fire | tmo_norm | (pin_low & state != ST_HOLD);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      trip_level_code       <= `RSC_TRIP_RST;
      idle_sysclk_keep      <= 1'b0;
      clk_src               <= `RSC_CLKSRC_RST;
      low_supply_reset_flag <= 1'b0;
      bad_trip_flag         <= 1'b0;
      bad_wde_flag          <= 1'b0;
    end else begin
      if (soft_full) begin
        trip_level_code  <= `RSC_TRIP_RST;
        idle_sysclk_keep <= 1'b0;
      end else begin
        if (wr_tr) begin
          trip_level_code <= wb_dat_i[7:0];
        end
        if (wr_ca) begin
          idle_sysclk_keep <= wb_dat_i[`RSC_BIT_KEEP];
        end
      end
      if (wr_cs) begin
        clk_src <= wb_dat_i[2:0];
      end
      low_supply_reset_flag <= (low_supply_reset_flag &
                               ~(wr_ca & ~wb_dat_i[`RSC_BIT_LOWSUP])) |
                               (supply_lo & state != ST_HOLD);
      bad_trip_flag <= (bad_trip_flag & ~(wr_ca & ~wb_dat_i[`RSC_BIT_BADTRIP]))
                       | trip_fire;
      bad_wde_flag <= (bad_wde_flag & ~(wr_ca & ~wb_dat_i[`RSC_BIT_BADWDE]))
                      | wde_fire;
    end
  end

  // ****************************************
  // timeout and powerdown status
  // ****************************************
  // power-on clears both; pin and supply resets leave them
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      watchdog_timeout_flag <= 1'b0;
      powerdown_flag        <= 1'b0;
    end else begin
      if (watchdog_timeout) begin
        watchdog_timeout_flag <= 1'b1;
        if (low_power_mode) begin
          powerdown_flag <= 1'b1;
        end
      end else if (halt_enter) begin
        watchdog_timeout_flag <= 1'b0;
        powerdown_flag        <= 1'b1;
      end else if (watchdog_clear) begin
        watchdog_timeout_flag <= 1'b0;
        powerdown_flag        <= 1'b0;
      end
    end
  end

  // ****************************************
  // wishbone answer
  // ****************************************
  // one-cycle answer; unmapped reads return zero
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (req) begin
        case (wb_adr_i)
          `RSC_OFF_TRIP:   wb_dat_o <= {24'h00_0000, trip_level_code};
          `RSC_OFF_CAUSE:  wb_dat_o <= {24'h00_0000, idle_sysclk_keep,
                                        4'h0, low_supply_reset_flag,
                                        bad_trip_flag, bad_wde_flag};
          `RSC_OFF_STATUS: wb_dat_o <= {30'h0000_0000, powerdown_flag,
                                        watchdog_timeout_flag};
          `RSC_OFF_CLKSRC: wb_dat_o <= {29'h0000_0000, clk_src};
          default:         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// *** verilog/rsc_defines.vh ***
// constants for the reset source control block
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define RSC_OFF_TRIP    8'h00
`define RSC_OFF_CAUSE   8'h04
`define RSC_OFF_STATUS  8'h08
`define RSC_OFF_CLKSRC  8'h0c

// ****************************************
// fields and reset values
// ****************************************
`define RSC_TRIP_RST    8'h55
`define RSC_TRIP_LVL0   8'h55
`define RSC_TRIP_LVL1   8'h33
`define RSC_TRIP_LVL2   8'h99
`define RSC_TRIP_LVL3   8'haa
`define RSC_WDE_OFF     5'h15
`define RSC_WDE_ON      5'h0a
`define RSC_BIT_KEEP    7
`define RSC_BIT_LOWSUP  2
`define RSC_BIT_BADTRIP 1
`define RSC_BIT_BADWDE  0
`define RSC_BIT_TMO     0
`define RSC_BIT_PWRDN   1
`define RSC_CLKSRC_RST  3'h1

// clock source codes
`define RSC_SRC_EXTRC   3'h0
`define RSC_SRC_FASTRC  3'h1
`define RSC_SRC_FASTXT  3'h2
`define RSC_SRC_SLOWXT  3'h3
`define RSC_SRC_SLOWRC  3'h4

// ****************************************
// timing: startup waits in system clocks, debounce in slow-oscillator edges
// ****************************************
`define RSC_SST_RC      11'd16
`define RSC_SST_XTAL    11'd1024
`define RSC_SST_SLOW    11'd2
`define RSC_DEB_EDGES   2'd3

`endif

// *** verilog/rsc_debounce.v ***
// slow-oscillator debounce for an illegal control code
`timescale 1ns/1ps
module rsc_debounce (
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // fault detection
  input  wire       slow_rise,
  input  wire       fault,
  // reset request
  output reg        fire
);
`include "rsc_defines.vh"

  reg [1:0] edge_cnt;

  // ****************************************
  // edge counter
  // ****************************************
  // slow counted delay
  // three edges from an arbitrary phase give two to three periods
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      edge_cnt <= 2'd0;
      fire     <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!fault) begin
        edge_cnt <= 2'd0;
      end else if (slow_rise) begin
        if (edge_cnt == `RSC_DEB_EDGES - 2'd1) begin
          fire     <= 1'b1;
          edge_cnt <= 2'd0;
        end else begin
          edge_cnt <= edge_cnt + 2'd1;
        end
      end
    end
  end

endmodule

// *** tb/rsc_reset_ctrl_asserts.sv ***
// concurrent checks on the reset source control ports
`timescale 1ns/1ps
module rsc_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       sys_rst,
  // bus and events
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire       wb_ack_o,
  input wire       external_reset_pin_n,
  input wire       watchdog_timeout,
  input wire       low_power_mode,
  // watched outputs
  input wire [7:0] trip_level_code,
  input wire       device_reset,
  input wire       pc_sp_clear,
  input wire       watchdog_restart,
  input wire       watchdog_timeout_flag,
  input wire       powerdown_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // timeout while asleep versus while running
  sequence lp_hit_s;
    watchdog_timeout && low_power_mode && !device_reset;
  endsequence
  sequence lp_done_s;
    ##[1:3] pc_sp_clear ##[0:2] (watchdog_timeout_flag && powerdown_flag);
  endsequence
  sequence norm_hit_s;
    watchdog_timeout && !low_power_mode && !device_reset;
  endsequence
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  lp_timeout_a: assert property (lp_hit_s |-> lp_done_s)
    else $error("sleep timeout effects missing");
  lp_no_reset_a: assert property (lp_hit_s |=> (!device_reset)[*4])
    else $error("sleep timeout reset the core");
  norm_timeout_a: assert property (norm_hit_s |-> ##[1:4] (device_reset && watchdog_timeout_flag))
    else $error("run timeout effects missing");
  pin_reset_a: assert property (!external_reset_pin_n |-> ##[1:4] device_reset)
    else $error("pin reset not applied");
  startup_hold_a: assert property ($fell(sys_rst) |-> device_reset[*8])
    else $error("core released too early");
  watchdog_restart_a: assert property ($fell(device_reset) |-> ##[0:1] watchdog_restart)
    else $error("watchdog not restarted");
  clear_pulse_a: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("pc sp clear held too long");
  trip_change_a: assert property ($changed(trip_level_code) |->
    trip_level_code == 8'h55 || $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("trip code changed on its own");
  por_flags_a: assert property (disable iff (1'b0) sys_rst |=>
    !watchdog_timeout_flag && !powerdown_flag)
    else $error("flags not cleared by power-on");
endmodule

bind rsc_reset_ctrl rsc_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .watchdog_timeout(watchdog_timeout),
  .external_reset_pin_n(external_reset_pin_n), .low_power_mode(low_power_mode),
  .trip_level_code(trip_level_code), .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
  .watchdog_restart(watchdog_restart), .watchdog_timeout_flag(watchdog_timeout_flag),
  .powerdown_flag(powerdown_flag));

// *** tb/test_reset_source_control.sv ***
// self-checking bench for the reset source control block
`timescale 1ns/1ps
module test_reset_source_control;
  reg        clk_sys = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, pin_n = 1;
  reg        trip = 0, slow = 0, wdog = 0, lp = 0, halt = 0, wclr = 0;
  reg [7:0]  adr = 8'h00;
  reg [31:0] dat = 32'h0000_0000, q, v;
  reg [4:0]  wde = 5'h0a;
  reg [3:0]  sdiv = 4'h0;
  wire [31:0] rdat;
  wire        ack, dr, psc;
  wire [7:0]  tcode;
  wire        wrst, tflag, pflag, keep;
  integer     error_cnt = 0, compares = 0, n, m, i;
  // slow oscillator, one period per 16 system clocks
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    sdiv <= sdiv + 4'h1;
    slow <= sdiv[3];
  end
  rsc_reset_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_reset_pin_n(pin_n), .low_supply_trip(trip), .slow_internal_rc(slow),
    .watchdog_timeout(wdog), .watchdog_enable_code(wde), .low_power_mode(lp), .halt_enter(halt),
    .watchdog_clear(wclr), .trip_level_code(tcode), .device_reset(dr), .pc_sp_clear(psc),
    .watchdog_restart(wrst), .watchdog_timeout_flag(tflag), .powerdown_flag(pflag),
    .idle_sysclk_keep(keep));
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // one classic cycle; waits for ack under a bound
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      n = 0;
      do begin
        @(posedge clk_sys);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      if (n >= 20) chk("ack", 0, 1);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    begin
      wb(0, a, 0);
      chk(nm, q, e);
    end
  endtask
  // m counts the cycles spent waiting
  task waitdr(input x);
    begin
      m = 0;
      while (dr !== x && m < 1500) begin
        @(posedge clk_sys);
        m = m + 1;
      end
      if (m >= 1500) chk("core reset wait", 0, 1);
    end
  endtask
  task tpulse;
    begin
      @(posedge clk_sys) wdog <= 1;
      @(posedge clk_sys) wdog <= 0;
    end
  endtask
  function legal(input [7:0] c);
    legal = c == 8'h55 || c == 8'h33 || c == 8'h99 || c == 8'haa;
  endfunction
  function integer sst(input integer s);
    sst = (s == 2 || s == 3) ? 1024 : (s == 4) ? 2 : 16;
  endfunction
  task test_done;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    test_done;
  end
  initial begin
    v = $urandom(32'h0000_76b5);
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    waitdr(0);
    chk("restart pulse", wrst, 1);
    chk("trip port", tcode, 8'h55);
    rd(8'h00, 8'h55, "trip rst");
    rd(8'h04, 0, "cause rst");
    rd(8'h08, 0, "status rst");
    rd(8'h10, 0, "unmapped");
    $display("test reset values done");
    for (i = 0; i < 4; i = i + 1) begin
      v = (i == 0) ? 8'h33 : (i == 1) ? 8'h99 : (i == 2) ? 8'haa : 8'h55;
      wb(1, 8'h00, v);
      rd(8'h00, v, "legal code");
      repeat (60) @(posedge clk_sys);
      chk("legal no reset", dr, 0);
    end
    $display("test legal codes done");
    for (i = 0; i < 3; i = i + 1) begin
      v = $urandom;
      while (legal(v[7:0])) v = $urandom;
      wb(1, 8'h00, {24'h00_0000, v[7:0]});
      waitdr(1);
      chk("debounce min", m >= 28, 1);
      chk("debounce max", m <= 56, 1);
      waitdr(0);
      rd(8'h00, 8'h55, "trip default");
      rd(8'h04, 2, "bad trip flag");
      wb(1, 8'h04, 0);
      wb(1, 8'h04, 8'h07);
      rd(8'h04, 0, "flag no set");
    end
    $display("test illegal codes done");
    for (i = 0; i < 5; i = i + 1) begin
      wb(1, 8'h00, 8'h99);
      wb(1, 8'h0c, i);
      @(posedge clk_sys) trip <= 1;
      waitdr(1);
      trip <= 0;
      waitdr(0);
      chk("startup min", m >= sst(i) - 1, 1);
      chk("startup max", m <= sst(i) + 5, 1);
      rd(8'h00, 8'h99, "trip kept");
      rd(8'h04, 4, "low supply flag");
      wb(1, 8'h04, 0);
    end
    wb(1, 8'h0c, 1);
    $display("test supply trip done");
    v = $urandom;
    while (v[4:0] == 5'h15 || v[4:0] == 5'h0a) v = $urandom;
    @(posedge clk_sys) wde <= v[4:0];
    waitdr(1);
    wde <= 5'h0a;
    waitdr(0);
    rd(8'h04, 1, "bad enable flag");
    wb(1, 8'h04, 0);
    $display("test enable code done");
    wb(1, 8'h00, 8'h33);
    tpulse;
    waitdr(1);
    waitdr(0);
    rd(8'h08, 1, "status timeout");
    rd(8'h00, 8'h55, "trip as pin");
    @(posedge clk_sys) pin_n <= 0;
    repeat (5) @(posedge clk_sys);
    pin_n <= 1;
    waitdr(0);
    rd(8'h08, 1, "status pin");
    $display("test run timeout done");
    wb(1, 8'h04, 8'h80);
    wb(1, 8'h00, 8'haa);
    @(posedge clk_sys) lp <= 1;
    tpulse;
    m = 0;
    while (psc !== 1'b1 && m < 10) begin
      @(posedge clk_sys);
      m = m + 1;
    end
    chk("pc sp clear", psc, 1);
    chk("core kept", dr, 0);
    repeat (30) @(posedge clk_sys);
    lp <= 0;
    rd(8'h08, 3, "status sleep");
    rd(8'h00, 8'haa, "trip sleep");
    chk("keep sleep", keep, 1);
    chk("flag ports", {tflag, pflag}, 2'b11);
    chk("trip port", tcode, 8'haa);
    @(posedge clk_sys) wclr <= 1;
    @(posedge clk_sys) wclr <= 0;
    rd(8'h08, 0, "status clear");
    @(posedge clk_sys) halt <= 1;
    @(posedge clk_sys) halt <= 0;
    rd(8'h08, 2, "status halt");
    $display("test sleep timeout done");
    @(posedge clk_sys) sys_rst <= 1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    waitdr(0);
    chk("restart por", wrst, 1);
    chk("keep por", keep, 0);
    rd(8'h08, 0, "status por");
    rd(8'h00, 8'h55, "trip por");
    $display("test power-on done");
    test_done;
  end
endmodule
